// [include/sadc_pkg.sv]
// constants and types shared by the serial converter control logic
package sadc_pkg;

  localparam int          SADC_RESULT_BITS = 8;
  localparam int          SADC_CODES       = 256;
  localparam int          SADC_LSB_BITS    = SADC_RESULT_BITS - 1;
  localparam int          SADC_FIFO_DEPTH  = 16;
  localparam logic [7:0]  SADC_TRIAL_RESET = 8'h80;
  localparam logic [7:0]  SADC_RESULT_RST  = 8'h00;
  localparam logic [2:0]  SADC_CNT_RST     = 3'h0;
  localparam logic [2:0]  SADC_CNT_LAST    = 3'(SADC_RESULT_BITS - 1);
  localparam logic [2:0]  SADC_LSB_LAST    = 3'(SADC_LSB_BITS - 1);
  localparam logic [2:0]  SADC_MUX_LAST    = 3'h1;
  // multiplexer word encoding
  localparam logic        SADC_MODE_SINGLE = 1'b1;
  localparam logic        SADC_MODE_DIFF   = 1'b0;

  typedef enum logic [2:0] {
    SADC_IDLE,
    SADC_WAIT_START,
    SADC_ADDR,
    SADC_SETTLE,
    SADC_CONV,
    SADC_LSB_OUT,
    SADC_TAIL
  } sadc_state_t;

endpackage

// [include/sadc_stream_if.sv]
// valid/ready stream carrying conversion results between the controller and its fifo
`timescale 1ns/10ps
interface sadc_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// [rtl/sadc_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module sadc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  sadc_stream_if.sink   wr,
  sadc_stream_if.source rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  wire              do_push;
  wire              do_pop;
  wire  [AW-1:0]    wr_ptr_inc;
  wire  [AW-1:0]    rd_ptr_inc;

  assign wr.ready   = (count_r != CW'(DEPTH));
  assign rd.valid   = (count_r != '0);
  assign rd.data    = mem_r[rd_ptr_r];
  assign do_push    = wr.valid & wr.ready;
  assign do_pop     = rd.valid & rd.ready;
  assign wr_ptr_inc = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_r + 1'b1);
  assign rd_ptr_inc = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_r + 1'b1);

  // storage has no reset: rd.valid needs a nonzero count, so only written entries are ever read
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= wr.data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_inc;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_inc;
      end
      if (do_push && !do_pop) begin
        count_r <= CW'(count_r + 1'b1);
      end else if (do_pop && !do_push) begin
        count_r <= CW'(count_r - 1'b1);
      end
    end
  end
endmodule

// [rtl/sadc_serial_ctrl.sv]
// serial link control, successive approximation sequencing and result buffering
`timescale 1ns/10ps
// Behaviour
// - chip select low starts a sequence awaiting start bit and multiplexer word.
// - each serial clock rise during addressing shifts in the serial input.
// - leading zeros are ignored; first sampled one is the start bit.
// - exactly two bits after the start bit form the multiplexer word.
// - half a clock of idle settling follows channel assignment.
// - serial input is ignored from settling until chip select rises.
// - output leaves high impedance and drives zero during settling.
// - each comparison bit is driven on the falling edge, MSB first.
// - conversion completes after eight clock periods, one bit each.
// - two-channel variant repeats the result LSB first right afterwards.
// - after the last bit the output stays low until chip select rises.
// - single-channel variant sends only the MSB-first stream.
// - input is sampled only while output is high impedance; host releases wire.
// - chip select high holds the logic in static low power.
// - chip select high keeps the output driver in high impedance.
// - result is 8 bits, 256 codes across the reference.
// - differential inputs are sampled half a clock period apart.
// - word bit one picks single or differential, bit two the channel.
// - single-channel variant has fixed polarity and no serial input or word.
// - positive input below negative gives an all-zeros code.
module sadc_serial_ctrl
  import sadc_pkg::*;
#(
  parameter bit DUAL_CHANNEL = 1'b1,
  parameter int FIFO_DEPTH   = SADC_FIFO_DEPTH
) (
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire logic                        cs_n,
  input  wire logic                        sclk,
  input  wire logic                        serial_in_line,
  output wire logic                        dout,
  output wire logic                        dout_oe,
  input  wire logic                        comp_high,
  output wire logic [SADC_RESULT_BITS-1:0] dac_code,
  output wire logic                        sample_pos,
  output wire logic                        sample_neg,
  output wire logic                        single_diff_select,
  output wire logic                        odd_sign,
  output wire logic                        low_power,
  output wire logic [SADC_RESULT_BITS-1:0] result_data,
  output wire logic                        result_valid,
  input  wire logic                        result_ready
);

  sadc_state_t                 state_r;
  sadc_state_t                 state_nxt;
  logic                        sclk_prev_r;
  logic [2:0]                  bit_cnt_r;
  logic [2:0]                  bit_cnt_nxt;
  logic                        single_diff_select_r;
  logic                        single_diff_select_nxt;
  logic                        odd_sign_r;
  logic                        odd_sign_nxt;
  logic                        settled_r;
  logic                        settled_nxt;
  logic [SADC_RESULT_BITS-1:0] trial_r;
  logic [SADC_RESULT_BITS-1:0] trial_nxt;
  logic [SADC_RESULT_BITS-1:0] shift_r;
  logic [SADC_RESULT_BITS-1:0] shift_nxt;
  logic                        dout_r;
  logic                        dout_nxt;
  logic                        oe_r;
  logic                        oe_nxt;
  logic                        sample_pos_r;
  logic                        sample_pos_nxt;
  logic                        sample_neg_r;
  logic                        sample_neg_nxt;
  logic                        push;

  wire                         sclk_rise;
  wire                         sclk_fall;
  wire                         conv_last;
  wire [SADC_RESULT_BITS-1:0]  bit_mask;
  wire [SADC_RESULT_BITS-1:0]  decided;
  wire                         lsb_expect;

  sadc_stream_if #(.WIDTH(SADC_RESULT_BITS)) push_if ();
  sadc_stream_if #(.WIDTH(SADC_RESULT_BITS)) pop_if ();

  // serial clock is taken as synchronous to clock; edges come from one delay stage
  assign sclk_rise = sclk & ~sclk_prev_r;
  assign sclk_fall = ~sclk & sclk_prev_r;
  assign conv_last = (bit_cnt_r == SADC_CNT_LAST);
  assign bit_mask  = SADC_TRIAL_RESET >> bit_cnt_r;
  // comparator low clears the trial bit; an inverted input pair never sets any bit
  assign decided   = comp_high ? trial_r : (trial_r & ~bit_mask);
  // finished code stays in the trial register, so the repeat can be checked against it
  assign lsb_expect = dac_code[3'(bit_cnt_r + 3'h1)];

  assign dout               = dout_r;
  assign dout_oe            = oe_r;
  assign dac_code           = trial_r;
  assign sample_pos         = sample_pos_r;
  assign sample_neg         = sample_neg_r;
  assign single_diff_select = single_diff_select_r;
  assign odd_sign           = odd_sign_r;
  assign low_power          = (state_r == SADC_IDLE);

  assign push_if.valid = push;
  assign push_if.data  = decided;
  assign result_data   = pop_if.data;
  assign result_valid  = pop_if.valid;
  assign pop_if.ready  = result_ready;

  always_comb begin
    state_nxt              = state_r;
    bit_cnt_nxt            = bit_cnt_r;
    single_diff_select_nxt = single_diff_select_r;
    odd_sign_nxt           = odd_sign_r;
    settled_nxt            = settled_r;
    trial_nxt              = trial_r;
    shift_nxt              = shift_r;
    dout_nxt               = dout_r;
    oe_nxt                 = oe_r;
    sample_pos_nxt         = 1'b0;
    sample_neg_nxt         = 1'b0;
    push                   = 1'b0;
    if (cs_n) begin
      // deselect aborts from any state and releases the wire
      state_nxt   = SADC_IDLE;
      oe_nxt      = 1'b0;
      dout_nxt    = 1'b0;
      settled_nxt = 1'b0;
    end else begin
      case (state_r)
        SADC_IDLE: begin
          state_nxt   = SADC_WAIT_START;
          bit_cnt_nxt = SADC_CNT_RST;
          trial_nxt   = SADC_TRIAL_RESET;
          settled_nxt = 1'b0;
        end
        SADC_WAIT_START: begin
          // a full result buffer holds off the next start bit rather than lose a result
          if (sclk_rise && push_if.ready) begin
            if (!DUAL_CHANNEL) begin
              state_nxt = SADC_SETTLE;
            end else if (serial_in_line) begin
              state_nxt = SADC_ADDR;
            end
          end
        end
        SADC_ADDR: begin
          if (sclk_rise) begin
            if (bit_cnt_r != SADC_MUX_LAST) begin
              single_diff_select_nxt = serial_in_line;
              bit_cnt_nxt            = 3'(bit_cnt_r + 1'b1);
            end else begin
              odd_sign_nxt = serial_in_line;
              bit_cnt_nxt  = SADC_CNT_RST;
              state_nxt    = SADC_SETTLE;
            end
          end
        end
        SADC_SETTLE: begin
          if (sclk_fall && !settled_r) begin
            oe_nxt         = 1'b1;
            dout_nxt       = 1'b0;
            sample_pos_nxt = 1'b1;
            settled_nxt    = 1'b1;
          end else if (sclk_rise && settled_r) begin
            sample_neg_nxt = 1'b1;
            state_nxt      = SADC_CONV;
          end
        end
        SADC_CONV: begin
          if (sclk_fall) begin
            dout_nxt  = comp_high;
            trial_nxt = decided | (bit_mask >> 1);
            if (conv_last) begin
              push        = 1'b1;
              shift_nxt   = decided >> 1;
              bit_cnt_nxt = SADC_CNT_RST;
              state_nxt   = DUAL_CHANNEL ? SADC_LSB_OUT : SADC_TAIL;
            end else begin
              bit_cnt_nxt = 3'(bit_cnt_r + 1'b1);
            end
          end
        end
        SADC_LSB_OUT: begin
          // bit 0 was already sent as the last MSB-first bit, so the repeat starts at bit 1
          if (sclk_fall) begin
            dout_nxt    = shift_r[0];
            shift_nxt   = shift_r >> 1;
            bit_cnt_nxt = 3'(bit_cnt_r + 1'b1);
            if (bit_cnt_r == SADC_LSB_LAST) begin
              state_nxt = SADC_TAIL;
            end
          end
        end
        SADC_TAIL: begin
          if (sclk_fall) begin
            dout_nxt = 1'b0;
          end
        end
        default: begin
          state_nxt = SADC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r              <= SADC_IDLE;
      sclk_prev_r          <= 1'b0;
      bit_cnt_r            <= SADC_CNT_RST;
      single_diff_select_r <= SADC_MODE_DIFF;
      odd_sign_r           <= 1'b0;
      settled_r            <= 1'b0;
      trial_r              <= SADC_TRIAL_RESET;
      shift_r              <= SADC_RESULT_RST;
    end else begin
      state_r              <= state_nxt;
      sclk_prev_r          <= sclk;
      bit_cnt_r            <= bit_cnt_nxt;
      single_diff_select_r <= single_diff_select_nxt;
      odd_sign_r           <= odd_sign_nxt;
      settled_r            <= settled_nxt;
      trial_r              <= trial_nxt;
      shift_r              <= shift_nxt;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dout_r       <= 1'b0;
      oe_r         <= 1'b0;
      sample_pos_r <= 1'b0;
      sample_neg_r <= 1'b0;
    end else begin
      dout_r       <= dout_nxt;
      oe_r         <= oe_nxt;
      sample_pos_r <= sample_pos_nxt;
      sample_neg_r <= sample_neg_nxt;
    end
  end

  sadc_fifo #(
    .WIDTH (SADC_RESULT_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr      (push_if),
    .rd      (pop_if)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence selected_s;
    !cs_n;
  endsequence

  sequence conv_last_s;
    selected_s and (state_r == SADC_CONV && sclk_fall && conv_last);
  endsequence

  sequence settle_fall_s;
    selected_s and (state_r == SADC_SETTLE && sclk_fall && !settled_r);
  endsequence

  sequence lsb_fall_s;
    selected_s and (state_r == SADC_LSB_OUT && sclk_fall);
  endsequence

  deselect_hiz_a: assert property (cs_n |=> !dout_oe && state_r == SADC_IDLE)
    else $error("output driven or state busy after deselect");

  deselect_power_a: assert property (cs_n ##1 cs_n |=> low_power)
    else $error("low power not held while deselected");

  start_bit_a: assert property (
    selected_s and (state_r == SADC_WAIT_START && sclk_rise && push_if.ready && DUAL_CHANNEL)
    |=> state_r == ($past(serial_in_line) ? SADC_ADDR : SADC_WAIT_START))
    else $error("start bit detection wrong");

  mux_first_a: assert property (
    selected_s and (state_r == SADC_ADDR && sclk_rise && bit_cnt_r == SADC_CNT_RST)
    |=> single_diff_select == $past(serial_in_line) && state_r == SADC_ADDR)
    else $error("first multiplexer bit not captured");

  mux_second_a: assert property (
    selected_s and (state_r == SADC_ADDR && sclk_rise && bit_cnt_r == SADC_MUX_LAST)
    |=> odd_sign == $past(serial_in_line) && state_r == SADC_SETTLE)
    else $error("second multiplexer bit not captured");

  settle_zero_a: assert property (settle_fall_s |=> dout_oe && !dout && sample_pos)
    else $error("settling zero not driven");

  sample_gap_a: assert property (
    sample_pos ##1 (!cs_n && !sclk_rise) [*1] |-> !sample_neg)
    else $error("negative input sampled without a rising edge");

  input_idle_a: assert property (
    selected_s and (state_r == SADC_CONV) |=> $stable(single_diff_select) && $stable(odd_sign))
    else $error("multiplexer word changed after settling");

  msb_bit_a: assert property (
    selected_s and (state_r == SADC_CONV && sclk_fall) |=> dout == $past(comp_high) && dout_oe)
    else $error("comparison bit not driven on falling edge");

  conv_push_a: assert property (conv_last_s |-> push_if.valid && push_if.ready)
    else $error("finished result not buffered");

  lsb_follow_a: assert property (
    conv_last_s |=> state_r == (DUAL_CHANNEL ? SADC_LSB_OUT : SADC_TAIL))
    else $error("wrong stream after conversion");

  tail_low_a: assert property (
    selected_s and (state_r == SADC_TAIL && sclk_fall) |=> dout_oe && !dout)
    else $error("trailing output not low");

  lsb_bit_a: assert property (lsb_fall_s |=> dout == $past(lsb_expect) && dout_oe)
    else $error("repeated result bit wrong");

  neg_sample_a: assert property (
    selected_s and (state_r == SADC_SETTLE && sclk_rise && settled_r)
    |=> sample_neg && state_r == SADC_CONV)
    else $error("negative input not sampled on the settling rise");

  trial_start_a: assert property (
    selected_s and (state_r == SADC_IDLE) |=> dac_code == SADC_TRIAL_RESET && bit_cnt_r == SADC_CNT_RST)
    else $error("trial code not reset at sequence start");

  trial_clear_a: assert property (
    selected_s and (state_r == SADC_CONV && sclk_fall && !comp_high)
    |=> (dac_code & $past(bit_mask)) == '0)
    else $error("rejected trial bit kept");

  addr_hiz_a: assert property (
    selected_s and (state_r == SADC_WAIT_START || state_r == SADC_ADDR) |-> !dout_oe)
    else $error("output driven while address is sampled");

  full_hold_a: assert property (
    selected_s and (state_r == SADC_WAIT_START && !push_if.ready) |=> state_r == SADC_WAIT_START)
    else $error("start taken while result buffer full");

  single_path_a: assert property (
    !DUAL_CHANNEL |-> state_r != SADC_ADDR && state_r != SADC_LSB_OUT)
    else $error("single-channel variant entered addressing or repeat");

endmodule

// [tb/sadc_host_model.sv]
// host side of the serial link: chip select, serial clock and the shared data wire
`timescale 1ns/10ps
module sadc_host_model #(
  parameter int HALF = 4
) (
  input  wire logic clock,
  output logic      cs_n,
  output logic      sclk,
  output logic      host_oe,
  output logic      host_bit,
  input  wire logic dout,
  input  wire logic dout_oe
);
  logic [17:0] seen;

  initial begin
    cs_n     = 1'b1;
    sclk     = 1'b0;
    host_oe  = 1'b0;
    host_bit = 1'b0;
    seen     = '0;
  end

  // every level lasts HALF clocks, far below the slowest allowed serial clock
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // zeros, start bit, two-bit word, then the wire is let go and falls are counted
  task automatic convert(input int zeros, input logic [1:0] word, input int falls);
    logic [2:0] addr;
    addr = {1'b1, word};
    cs_n = 1'b0;
    host_oe = 1'b1;
    wait_clk(HALF);
    for (int i = 0; i < zeros + 3; i++) begin
      host_bit = (i < zeros) ? 1'b0 : addr[zeros + 2 - i];
      wait_clk(HALF);
      sclk = 1'b1;
      wait_clk(HALF);
      if (i == zeros + 2) host_oe = 1'b0;
      sclk = 1'b0;
    end
    for (int k = 0; k < falls; k++) begin
      wait_clk(HALF);
      seen[k] = dout_oe ? dout : 1'bz;
      sclk = 1'b1;
      wait_clk(HALF);
      sclk = 1'b0;
    end
  endtask

  // serial clock stands low outside frames
  task automatic release_cs();
    wait_clk(HALF);
    cs_n = 1'b1;
    host_oe = 1'b0;
    wait_clk(3);
  endtask
endmodule

// [tb/serial_adc_conversion_interface_test.sv]
// self-checking bench for the serial converter control block
`timescale 1ns/10ps
module serial_adc_conversion_interface_test import sadc_pkg::*;;
  localparam int HALF = 4;
  logic                        clock;
  logic                        sys_rst;
  logic                        cs_n;
  logic                        sclk;
  logic                        serial_in_line;
  logic                        host_oe;
  logic                        host_bit;
  logic                        last_bit;
  logic                        dout;
  logic                        dout_oe;
  logic                        comp_high;
  logic [SADC_RESULT_BITS-1:0] dac_code;
  logic                        sample_pos;
  logic                        sample_neg;
  logic                        single_diff_select;
  logic                        odd_sign;
  logic                        low_power;
  logic [SADC_RESULT_BITS-1:0] result_data;
  logic                        result_valid;
  logic                        result_ready;
  logic                        dout_s;
  logic                        dout_oe_s;
  logic                        comp_high_s;
  logic [SADC_RESULT_BITS-1:0] dac_code_s;
  logic [SADC_RESULT_BITS-1:0] result_data_s;
  logic                        result_valid_s;
  logic [SADC_RESULT_BITS-1:0] target;
  logic [1:0]                  word;
  logic [7:0]                  exp_q[$];
  logic [7:0]                  exp_s_q[$];
  int                          mismatches;
  int                          total_checks;
  int                          cycles;
  int                          gap;
  int unsigned                 seed_v;

  // released wire toggles every cycle so a stale sample cannot pass
  assign serial_in_line = host_oe ? host_bit : (dout_oe ? dout : ~last_bit);
  assign comp_high = (target >= dac_code);
  assign comp_high_s = (target >= dac_code_s);

  sadc_host_model #(.HALF(HALF)) i_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .host_oe(host_oe),
    .host_bit(host_bit), .dout(dout), .dout_oe(dout_oe));

  sadc_serial_ctrl #(.DUAL_CHANNEL(1'b1), .FIFO_DEPTH(SADC_FIFO_DEPTH)) i_dut (.clock(clock),
    .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .serial_in_line(serial_in_line), .dout(dout),
    .dout_oe(dout_oe), .comp_high(comp_high), .dac_code(dac_code), .sample_pos(sample_pos),
    .sample_neg(sample_neg), .single_diff_select(single_diff_select), .odd_sign(odd_sign),
    .low_power(low_power), .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready));

  // single-channel variant shares the link; it ignores the serial input and starts on the first rise
  sadc_serial_ctrl #(.DUAL_CHANNEL(1'b0), .FIFO_DEPTH(SADC_FIFO_DEPTH)) i_dut_single (.clock(clock),
    .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .serial_in_line(serial_in_line), .dout(dout_s),
    .dout_oe(dout_oe_s), .comp_high(comp_high_s), .dac_code(dac_code_s), .sample_pos(), .sample_neg(),
    .single_diff_select(), .odd_sign(), .low_power(), .result_data(result_data_s),
    .result_valid(result_valid_s), .result_ready(result_ready));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic exp_bit(input logic [7:0] t, input int k);
    if (k >= 1 && k <= 8) return t[8 - k];
    if (k >= 9 && k <= 15) return t[k - 8];
    return 1'b0;
  endfunction

  task automatic run_one(input int zeros, input int falls, input bit full);
    if (falls == 18) exp_q.push_back(target);
    // the single variant finishes nine falls after its first rise, address falls included
    if (!full && zeros + falls >= 6) exp_s_q.push_back(target);
    i_host.convert(zeros, word, falls);
    for (int k = 0; k < falls; k++) begin
      check("dout_bit", i_host.seen[k], full ? 1'bz : exp_bit(target, k));
    end
    if (!full) check("mux_word", {single_diff_select, odd_sign}, word);
    if (!full) check("awake", low_power, 1'b0);
    if (falls == 18) check("single_tail", {dout_oe_s, dout_s}, 2'b10);
    i_host.release_cs();
    check("oe_idle", dout_oe, 1'b0);
    check("low_power", low_power, 1'b1);
  endtask

  always @(posedge clock) begin
    last_bit <= #1 serial_in_line;
    if (sample_pos === 1'b1) gap = 0;
    else gap++;
    if (sample_neg === 1'b1) check("pos_neg_gap", gap, HALF);
    if (result_valid === 1'b1 && result_ready === 1'b1) begin
      if (exp_q.size() == 0) check("extra_result", 1, 0);
      else check("result_data", result_data, exp_q.pop_front());
    end
    if (result_valid_s === 1'b1 && result_ready === 1'b1) begin
      if (exp_s_q.size() == 0) check("extra_single", 1, 0);
      else check("single_data", result_data_s, exp_s_q.pop_front());
    end
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    sys_rst = 1'b1;
    result_ready = 1'b0;
    target = 8'h00;
    word = 2'h0;
    last_bit = 1'b0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    gap = 0;
    seed_v = $urandom(89);
    repeat (10) @(posedge clock);
    #1 sys_rst = 1'b0;
    check("rst_low_power", low_power, 1'b1);
    check("rst_oe", dout_oe, 1'b0);
    for (int n = 0; n < SADC_FIFO_DEPTH; n++) begin
      target = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : 8'($urandom());
      word = (n < 4) ? 2'(n) : 2'($urandom());
      run_one(n % 4, 18, 1'b0);
    end
    check("fifo_full_valid", result_valid, 1'b1);
    check("fifo_full_single", result_valid_s, 1'b1);
    // full buffer holds back the next start, so the output never leaves high impedance
    run_one(0, 3, 1'b1);
    for (int w = 0; w < 400 && (exp_q.size() > 0 || exp_s_q.size() > 0); w++) begin
      @(posedge clock);
      #1 result_ready = 1'($urandom());
    end
    #1 check("drained", result_valid, 1'b0);
    check("drained_single", result_valid_s, 1'b0);
    // later results must drain whatever the last random draw was
    result_ready = 1'b1;
    // abort after four result bits, then a whole sequence must still work
    target = 8'($urandom());
    word = 2'h2;
    run_one(1, 5, 1'b0);
    target = 8'h5A;
    word = 2'h1;
    run_one(2, 18, 1'b0);
    for (int w = 0; w < 100 && (exp_q.size() > 0 || exp_s_q.size() > 0); w++) @(posedge clock);
    check("results_left", exp_q.size(), 0);
    check("results_left_single", exp_s_q.size(), 0);
    complete_run();
  end
endmodule
